/* design/bfc_consts.svh */
// bfc_consts.svh: offsets, field positions, reset values and sizes of the block ram fifo core
// assumes: included by its bare name from the package and from every design file
`ifndef BFC_CONSTS_SVH
`define BFC_CONSTS_SVH

`define BFC_ADDR_W        9
`define BFC_DATA_W        18
`define BFC_LVL_W         10
`define BFC_INT_W         6

`define BFC_OFF_CTRL      8'h00
`define BFC_OFF_THR_FULL  8'h04
`define BFC_OFF_THR_AF    8'h08
`define BFC_OFF_THR_AE    8'h0c
`define BFC_OFF_STATUS    8'h10
`define BFC_OFF_INT_STAT  8'h14
`define BFC_OFF_INT_MASK  8'h18

`define BFC_CTRL_WMA_LO   0
`define BFC_CTRL_WMB_LO   2
`define BFC_CTRL_ASYNC    4
`define BFC_CTRL_FIFO     5

`define BFC_INT_FULL      0
`define BFC_INT_AFULL     1
`define BFC_INT_AEMPTY    2
`define BFC_INT_EMPTY     3
`define BFC_INT_OVER      4
`define BFC_INT_UNDER     5

`define BFC_RST_CTRL      6'h00
`define BFC_RST_THR_FULL  9'h1ff
`define BFC_RST_THR_AF    9'h1c0
`define BFC_RST_THR_AE    9'h040
`define BFC_RST_INT_MASK  6'h00
`define BFC_THR_MIN       9'h001

`endif

/* design/bfc_pkg.sv */
// bfc_pkg: types and shared helpers of the block ram fifo core
// assumes: bfc_consts.svh is on the include path
`default_nettype none
`include "bfc_consts.svh"

package bfc_pkg;

  typedef enum logic [1:0] {wm_normal, wm_through, wm_rbw} bfc_wmode_t;

  typedef struct packed {
    logic                   en;
    logic                   we;
    logic [`BFC_ADDR_W-1:0] addr;
    logic [`BFC_DATA_W-1:0] din;
  } bfc_port_req_t;

  typedef struct packed {
    logic full;
    logic almost_full;
    logic almost_empty;
    logic empty;
  } bfc_flags_t;

  // fill level from pointers with one wrap bit
  function automatic logic [`BFC_LVL_W-1:0] bfc_level(input logic [`BFC_LVL_W-1:0] w,
                                                      input logic [`BFC_LVL_W-1:0] r);
    bfc_level = w - r;
  endfunction : bfc_level

endpackage : bfc_pkg

`default_nettype wire

/* design/bfc_dpram.sv */
// bfc_dpram: dual port block ram with per-port write-output behaviour and resettable output latches
// assumes: both ports on one clock; clear inputs come from logic on that clock
`default_nettype none
`include "bfc_consts.svh"

module bfc_dpram
  import bfc_pkg::*;
(
  // clock and reset
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  // port requests
  input  wire bfc_port_req_t          req_a,
  input  wire bfc_port_req_t          req_b,
  input  wire bfc_wmode_t             wmode_a,
  input  wire bfc_wmode_t             wmode_b,
  // latch resets
  input  wire logic                   latch_async,
  input  wire logic                   clr_a,
  input  wire logic                   clr_b,
  input  wire logic                   chip_clr_n,
  // read data
  output logic [`BFC_DATA_W-1:0]      dout_a,
  output logic [`BFC_DATA_W-1:0]      dout_b
);

  logic [`BFC_DATA_W-1:0] mem [0:(1<<`BFC_ADDR_W)-1];
  logic [`BFC_DATA_W-1:0] dout_a_d;
  logic [`BFC_DATA_W-1:0] dout_b_d;
  logic                   arst_a_n;
  logic                   arst_b_n;

  // output value of one port for this cycle
  function automatic logic [`BFC_DATA_W-1:0] port_next(input bfc_port_req_t r, input bfc_wmode_t m,
                                                       input logic [`BFC_DATA_W-1:0] old,
                                                       input logic [`BFC_DATA_W-1:0] cur,
                                                       input logic sclr);
    port_next = cur;
    if (sclr) begin
      port_next = '0;
    end else if (r.en && !r.we) begin
      port_next = old;
    end else if (r.en) begin
      case (m)
        wm_through: port_next = r.din;
        wm_rbw:     port_next = old;
        default:    port_next = cur;
      endcase
    end
  endfunction : port_next

  // async clear gated by the mode bit; a glitch-free select is the user's duty
  assign arst_a_n = rst_n & ~(latch_async & (clr_a | ~chip_clr_n));
  assign arst_b_n = rst_n & ~(latch_async & (clr_b | ~chip_clr_n));

  always_comb begin
    dout_a_d = port_next(req_a, wmode_a, mem[req_a.addr], dout_a, !latch_async && (clr_a || !chip_clr_n));
    dout_b_d = port_next(req_b, wmode_b, mem[req_b.addr], dout_b, !latch_async && (clr_b || !chip_clr_n));
  end

  // port b wins a same-address write collision
  always_ff @(posedge clk) begin
    if (req_a.en && req_a.we) begin
      mem[req_a.addr] <= req_a.din;
    end
    if (req_b.en && req_b.we) begin
      mem[req_b.addr] <= req_b.din;
    end
  end

  always_ff @(posedge clk or negedge arst_a_n) begin
    if (!arst_a_n) begin
      dout_a <= '0;
    end else begin
      dout_a <= dout_a_d;
    end
  end

  always_ff @(posedge clk or negedge arst_b_n) begin
    if (!arst_b_n) begin
      dout_b <= '0;
    end else begin
      dout_b <= dout_b_d;
    end
  end

endmodule : bfc_dpram

`default_nettype wire

/* design/bfc_flags.sv */
// bfc_flags: fifo pointers and registered full, almost-full, almost-empty and empty flags
// assumes: write and read sides share one clock; thresholds already lie in their legal range
`default_nettype none
`include "bfc_consts.svh"

module bfc_flags
  import bfc_pkg::*;
(
  // clock and reset
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  // control
  input  wire logic                   fifo_clear,
  input  wire logic                   rp_clear,
  input  wire logic                   wr_req,
  input  wire logic                   rd_req,
  input  wire logic [`BFC_ADDR_W-1:0] thr_full,
  input  wire logic [`BFC_ADDR_W-1:0] thr_af,
  input  wire logic [`BFC_ADDR_W-1:0] thr_ae,
  // state
  output logic                        wr_ok,
  output logic                        rd_ok,
  output logic [`BFC_ADDR_W-1:0]      wr_addr,
  output logic [`BFC_ADDR_W-1:0]      rd_addr,
  output logic [`BFC_LVL_W-1:0]       level,
  output bfc_flags_t                  flags_q
);

  logic [`BFC_LVL_W-1:0] wptr_q;
  logic [`BFC_LVL_W-1:0] wptr_d;
  logic [`BFC_LVL_W-1:0] rptr_q;
  logic [`BFC_LVL_W-1:0] rptr_d;
  logic [`BFC_LVL_W-1:0] lvl_d;
  bfc_flags_t            flags_d;

  assign wr_ok   = wr_req && !flags_q.full;
  assign rd_ok   = rd_req && !flags_q.empty;
  assign wr_addr = wptr_q[`BFC_ADDR_W-1:0];
  assign rd_addr = rptr_q[`BFC_ADDR_W-1:0];
  assign level   = bfc_level(wptr_q, rptr_q);

  always_comb begin
    wptr_d = wptr_q + {{(`BFC_LVL_W-1){1'b0}}, wr_ok};
    rptr_d = rptr_q + {{(`BFC_LVL_W-1){1'b0}}, rd_ok};
    if (rp_clear) begin
      rptr_d = '0;
    end
    if (fifo_clear) begin
      wptr_d = '0;
      rptr_d = '0;
    end
    lvl_d = bfc_level(wptr_d, rptr_d);
    // flags judged on next pointers so they move on the same edge
    flags_d.full         = lvl_d >= {1'b0, thr_full};
    flags_d.almost_full  = lvl_d >= {1'b0, thr_af};
    flags_d.almost_empty = lvl_d <= {1'b0, thr_ae};
    flags_d.empty        = lvl_d == '0;
  end

  // write-side and read-side flags share the one clock here
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wptr_q  <= '0;
      rptr_q  <= '0;
      flags_q <= 4'b0011;
    end else begin
      wptr_q  <= wptr_d;
      rptr_q  <= rptr_d;
      flags_q <= flags_d;
    end
  end

endmodule : bfc_flags

`default_nettype wire

/* design/bfc_top.sv */
// bfc_top: block ram with selectable write behaviour, fifo mode, latch resets and an ahb-lite register slave
// assumes: all user-side inputs come from logic on hclk; single-word ahb transfers, one master
`default_nettype none
`include "bfc_consts.svh"

module bfc_top
  import bfc_pkg::*;
(
  // clock and reset
  input  wire logic                   hclk,
  input  wire logic                   hresetn,
  // ahb-lite slave
  input  wire logic                   hsel,
  input  wire logic [31:0]            haddr,
  input  wire logic [1:0]             htrans,
  input  wire logic                   hwrite,
  input  wire logic [2:0]             hsize,
  input  wire logic                   hready,
  input  wire logic [31:0]            hwdata,
  output logic [31:0]                 hrdata,
  output logic                        hreadyout,
  output logic                        hresp,
  // ram port a (ram mode)
  input  wire logic                   a_en,
  input  wire logic                   a_we,
  input  wire logic [`BFC_ADDR_W-1:0] a_addr,
  input  wire logic [`BFC_DATA_W-1:0] a_din,
  output logic [`BFC_DATA_W-1:0]      a_dout,
  // ram port b (ram mode), also fifo read data
  input  wire logic                   b_en,
  input  wire logic                   b_we,
  input  wire logic [`BFC_ADDR_W-1:0] b_addr,
  input  wire logic [`BFC_DATA_W-1:0] b_din,
  output logic [`BFC_DATA_W-1:0]      b_dout,
  // fifo write side
  input  wire logic [`BFC_DATA_W-1:0] wr_data,
  input  wire logic                   wr_clk_en,
  input  wire logic                   wr_en,
  // fifo read side
  input  wire logic                   rd_clk_en,
  input  wire logic                   rd_strobe,
  // fifo resets
  input  wire logic                   fifo_reset,
  input  wire logic                   rd_ptr_clear,
  // latch resets
  input  wire logic                   port_a_latch_clear,
  input  wire logic                   port_b_latch_clear,
  input  wire logic                   chip_wide_clear_n,
  // flags and interrupt
  output logic                        full_flag,
  output logic                        almost_full_flag,
  output logic                        almost_empty_flag,
  output logic                        empty_flag,
  output logic                        irq
);

  // register state
  logic [5:0]             ctrl_q;
  logic [5:0]             ctrl_d;
  logic [`BFC_ADDR_W-1:0] thr_full_q;
  logic [`BFC_ADDR_W-1:0] thr_full_d;
  logic [`BFC_ADDR_W-1:0] thr_af_q;
  logic [`BFC_ADDR_W-1:0] thr_af_d;
  logic [`BFC_ADDR_W-1:0] thr_ae_q;
  logic [`BFC_ADDR_W-1:0] thr_ae_d;
  logic [`BFC_INT_W-1:0]  int_stat_q;
  logic [`BFC_INT_W-1:0]  int_stat_d;
  logic [`BFC_INT_W-1:0]  int_mask_q;
  logic [`BFC_INT_W-1:0]  int_mask_d;
  logic                   irq_d;

  // bus state
  logic                   wr_pend_q;
  logic                   wr_pend_d;
  logic [7:0]             waddr_q;
  logic [7:0]             waddr_d;
  logic [31:0]            rdata_q;
  logic [31:0]            rdata_d;
  logic                   accept;

  // fifo and ram wiring
  logic                   fifo_en;
  logic                   wr_req;
  logic                   rd_req;
  logic                   wr_ok;
  logic                   rd_ok;
  logic [`BFC_ADDR_W-1:0] wr_addr;
  logic [`BFC_ADDR_W-1:0] rd_addr;
  logic [`BFC_LVL_W-1:0]  level;
  bfc_flags_t             flags_q;
  bfc_flags_t             flags_prev_q;
  bfc_port_req_t          req_a;
  bfc_port_req_t          req_b;
  logic [`BFC_INT_W-1:0]  events;

  // keep a threshold inside lo..hi
  function automatic logic [`BFC_ADDR_W-1:0] clamp_thr(input logic [31:0] v,
                                                      input logic [`BFC_ADDR_W-1:0] hi);
    logic [`BFC_ADDR_W-1:0] t;
    t = v[`BFC_ADDR_W-1:0];
    if (v[31:`BFC_ADDR_W] != '0 || t > hi) begin
      t = hi;
    end
    if (t < `BFC_THR_MIN) begin
      t = `BFC_THR_MIN;
    end
    clamp_thr = t;
  endfunction : clamp_thr

  assign fifo_en = ctrl_q[`BFC_CTRL_FIFO];
  assign wr_req  = fifo_en && wr_clk_en && wr_en;
  assign rd_req  = fifo_en && rd_clk_en && rd_strobe;
  assign accept  = hsel && hready && htrans[1];

  // fifo mode turns port a into the write side and port b into the read side
  always_comb begin
    if (fifo_en) begin
      req_a = '{en: wr_ok, we: 1'b1, addr: wr_addr, din: wr_data};
      req_b = '{en: rd_ok, we: 1'b0, addr: rd_addr, din: '0};
    end else begin
      req_a = '{en: a_en, we: a_we, addr: a_addr, din: a_din};
      req_b = '{en: b_en, we: b_we, addr: b_addr, din: b_din};
    end
  end

  bfc_flags u_flags (
    .clk        (hclk),
    .rst_n      (hresetn),
    .fifo_clear (fifo_reset),
    .rp_clear   (rd_ptr_clear),
    .wr_req     (wr_req),
    .rd_req     (rd_req),
    .thr_full   (thr_full_q),
    .thr_af     (thr_af_q),
    .thr_ae     (thr_ae_q),
    .wr_ok      (wr_ok),
    .rd_ok      (rd_ok),
    .wr_addr    (wr_addr),
    .rd_addr    (rd_addr),
    .level      (level),
    .flags_q    (flags_q)
  );

  bfc_dpram u_ram (
    .clk         (hclk),
    .rst_n       (hresetn),
    .req_a       (req_a),
    .req_b       (req_b),
    .wmode_a     (bfc_wmode_t'(ctrl_q[`BFC_CTRL_WMA_LO +: 2])),
    .wmode_b     (bfc_wmode_t'(ctrl_q[`BFC_CTRL_WMB_LO +: 2])),
    .latch_async (ctrl_q[`BFC_CTRL_ASYNC]),
    .clr_a       (port_a_latch_clear),
    .clr_b       (port_b_latch_clear),
    .chip_clr_n  (chip_wide_clear_n),
    .dout_a      (a_dout),
    .dout_b      (b_dout)
  );

  assign full_flag         = flags_q.full;
  assign almost_full_flag  = flags_q.almost_full;
  assign almost_empty_flag = flags_q.almost_empty;
  assign empty_flag        = flags_q.empty;

  // flag rises and refused requests are the interrupt events
  always_comb begin
    events                  = '0;
    events[`BFC_INT_FULL]   = flags_q.full && !flags_prev_q.full;
    events[`BFC_INT_AFULL]  = flags_q.almost_full && !flags_prev_q.almost_full;
    events[`BFC_INT_AEMPTY] = flags_q.almost_empty && !flags_prev_q.almost_empty;
    events[`BFC_INT_EMPTY]  = flags_q.empty && !flags_prev_q.empty;
    events[`BFC_INT_OVER]   = wr_req && !wr_ok;
    events[`BFC_INT_UNDER]  = rd_req && !rd_ok;
  end

  // register writes land in the data phase; reads are sampled in the address phase
  always_comb begin
    ctrl_d     = ctrl_q;
    thr_full_d = thr_full_q;
    thr_af_d   = thr_af_q;
    thr_ae_d   = thr_ae_q;
    int_mask_d = int_mask_q;
    int_stat_d = int_stat_q;
    wr_pend_d  = accept && hwrite;
    waddr_d    = accept ? haddr[7:0] : waddr_q;
    rdata_d    = rdata_q;
    if (wr_pend_q) begin
      case (waddr_q)
        `BFC_OFF_CTRL:     ctrl_d     = hwdata[5:0];
        `BFC_OFF_THR_FULL: thr_full_d = clamp_thr(hwdata, {`BFC_ADDR_W{1'b1}});
        `BFC_OFF_THR_AF:   thr_af_d   = clamp_thr(hwdata, thr_full_q - 9'h001);
        `BFC_OFF_THR_AE:   thr_ae_d   = clamp_thr(hwdata, thr_full_q - 9'h001);
        `BFC_OFF_INT_STAT: int_stat_d = int_stat_q & ~hwdata[`BFC_INT_W-1:0];
        `BFC_OFF_INT_MASK: int_mask_d = hwdata[`BFC_INT_W-1:0];
        default:           ctrl_d     = ctrl_q;
      endcase
    end
    // a new event wins over a clear in the same cycle
    int_stat_d = int_stat_d | events;
    irq_d      = |(int_stat_d & int_mask_d);
    if (accept && !hwrite) begin
      rdata_d = '0;
      case (haddr[7:0])
        `BFC_OFF_CTRL:     rdata_d[5:0]              = ctrl_q;
        `BFC_OFF_THR_FULL: rdata_d[`BFC_ADDR_W-1:0]  = thr_full_q;
        `BFC_OFF_THR_AF:   rdata_d[`BFC_ADDR_W-1:0]  = thr_af_q;
        `BFC_OFF_THR_AE:   rdata_d[`BFC_ADDR_W-1:0]  = thr_ae_q;
        `BFC_OFF_STATUS:   rdata_d                   = {18'h00000, level, flags_q};
        `BFC_OFF_INT_STAT: rdata_d[`BFC_INT_W-1:0]   = int_stat_q;
        `BFC_OFF_INT_MASK: rdata_d[`BFC_INT_W-1:0]   = int_mask_q;
        default:           rdata_d                   = '0;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q       <= `BFC_RST_CTRL;
      thr_full_q   <= `BFC_RST_THR_FULL;
      thr_af_q     <= `BFC_RST_THR_AF;
      thr_ae_q     <= `BFC_RST_THR_AE;
      int_stat_q   <= '0;
      int_mask_q   <= `BFC_RST_INT_MASK;
      irq          <= 1'b0;
      flags_prev_q <= 4'b0011;
      wr_pend_q    <= 1'b0;
      waddr_q      <= '0;
      rdata_q      <= '0;
      hreadyout    <= 1'b1;
      hresp        <= 1'b0;
    end else begin
      ctrl_q       <= ctrl_d;
      thr_full_q   <= thr_full_d;
      thr_af_q     <= thr_af_d;
      thr_ae_q     <= thr_ae_d;
      int_stat_q   <= int_stat_d;
      int_mask_q   <= int_mask_d;
      irq          <= irq_d;
      flags_prev_q <= flags_q;
      wr_pend_q    <= wr_pend_d;
      waddr_q      <= waddr_d;
      rdata_q      <= rdata_d;
      hreadyout    <= 1'b1;
      hresp        <= 1'b0;
    end
  end

  assign hrdata = rdata_q;

endmodule : bfc_top

`default_nettype wire

/* sim/bfc_top_assertions.sv */
// bfc_top_assertions: concurrent checks on the ports of bfc_top
// assumes: bound from the bench; ctrl is shadowed from bus writes to offset 0x00
`default_nettype none
`include "bfc_consts.svh"

module bfc_top_assertions
  import bfc_pkg::*;
(
  // clock and reset
  input wire logic                   hclk,
  input wire logic                   hresetn,
  // bus
  input wire logic                   hsel,
  input wire logic [31:0]            haddr,
  input wire logic [1:0]             htrans,
  input wire logic                   hwrite,
  input wire logic                   hready,
  input wire logic [31:0]            hwdata,
  // ram ports
  input wire logic                   a_en,
  input wire logic                   a_we,
  input wire logic [`BFC_DATA_W-1:0] a_din,
  input wire logic [`BFC_DATA_W-1:0] a_dout,
  input wire logic                   b_en,
  input wire logic [`BFC_DATA_W-1:0] b_dout,
  // fifo sides and clears
  input wire logic                   wr_clk_en,
  input wire logic                   wr_en,
  input wire logic                   rd_clk_en,
  input wire logic                   rd_strobe,
  input wire logic                   fifo_reset,
  input wire logic                   rd_ptr_clear,
  input wire logic                   port_a_latch_clear,
  input wire logic                   port_b_latch_clear,
  input wire logic                   chip_wide_clear_n,
  // flags
  input wire logic                   full_flag,
  input wire logic                   almost_full_flag,
  input wire logic                   almost_empty_flag,
  input wire logic                   empty_flag
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  logic       pend_q;
  logic [5:0] ctrl_q;
  logic       fm, wq, rq, qt;

  // write data lands one edge after its address phase, as in the slave
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pend_q <= 1'b0;
      ctrl_q <= 6'h00;
    end else begin
      pend_q <= hsel & hready & htrans[1] & hwrite & (haddr[7:0] == 8'h00);
      if (pend_q) ctrl_q <= hwdata[5:0];
    end
  end
  assign fm = ctrl_q[5];
  assign wq = fm & wr_clk_en & wr_en;
  assign rq = fm & rd_clk_en & rd_strobe;
  assign qt = !port_a_latch_clear & !port_b_latch_clear & chip_wide_clear_n;

  sequence s_cleared;
    empty_flag && almost_empty_flag && !full_flag && !almost_full_flag;
  endsequence
  sequence s_push_full;
    full_flag && wq && !rq && !fifo_reset;
  endsequence

  property p_fifo_reset;
    fm && fifo_reset |=> s_cleared;
  endproperty
  property p_push_full;
    s_push_full |=> full_flag;
  endproperty
  property p_pop_empty;
    empty_flag && rq && !wq && !fifo_reset && !rd_ptr_clear && qt |=> empty_flag && $stable(b_dout);
  endproperty
  property p_push_fills;
    empty_flag && wq && !rq && !fifo_reset && !rd_ptr_clear |=> !empty_flag;
  endproperty
  property p_empty_hold;
    !wq && !rq && !fifo_reset && !rd_ptr_clear |=> $stable(empty_flag);
  endproperty
  property p_normal_hold;
    !fm && a_en && a_we && ctrl_q[1:0] == 2'd0 && qt |=> $stable(a_dout);
  endproperty
  property p_through;
    !fm && a_en && a_we && ctrl_q[1:0] == 2'd1 && qt |=> a_dout == $past(a_din);
  endproperty
  property p_local_clear;
    port_a_latch_clear && !port_b_latch_clear && chip_wide_clear_n && !b_en && !rq
      |=> a_dout == '0 && $stable(b_dout);
  endproperty
  property p_chip_clear;
    !chip_wide_clear_n |=> a_dout == '0 && b_dout == '0;
  endproperty
  property p_rewind;
    fm && rd_ptr_clear && !fifo_reset && !empty_flag |=> !empty_flag;
  endproperty

  a_fifo_reset: assert property (p_fifo_reset) else $error("flags not cleared");
  a_push_full: assert property (p_push_full) else $error("full dropped on push");
  a_pop_empty: assert property (p_pop_empty) else $error("read while empty moved");
  a_push_fills: assert property (p_push_fills) else $error("empty kept after push");
  a_empty_hold: assert property (p_empty_hold) else $error("empty changed idle");
  a_normal_hold: assert property (p_normal_hold) else $error("normal write moved dout");
  a_through: assert property (p_through) else $error("write data not on dout");
  a_local_clear: assert property (p_local_clear) else $error("local clear wrong");
  a_chip_clear: assert property (p_chip_clear) else $error("chip clear missed");
  a_rewind: assert property (p_rewind) else $error("rewind lost data");
endmodule : bfc_top_assertions

`default_nettype wire

/* sim/bfc_user_model.sv */
// bfc_user_model: user logic on the fifo write and read sides
// assumes: same clock as the block; the bench calls push and pop
`default_nettype none
`include "bfc_consts.svh"

module bfc_user_model
  import bfc_pkg::*;
(
  // clock
  input  wire logic              clk,
  // write side
  output logic [`BFC_DATA_W-1:0] wr_data,
  output logic                   wr_clk_en,
  output logic                   wr_en,
  // read side
  output logic                   rd_clk_en,
  output logic                   rd_strobe
);
  timeunit 1ns;
  timeprecision 1ps;
  int n_push;
  int n_pop;

  initial begin
    {wr_data, wr_clk_en, wr_en, rd_clk_en, rd_strobe} = '0;
    n_push = 0;
    n_pop = 0;
  end

  // stale data inverted so it never looks valid
  task automatic push(input logic [`BFC_DATA_W-1:0] d, input int gap);
    repeat (gap) @(posedge clk);
    @(posedge clk);
    wr_data <= d;
    wr_clk_en <= 1'b1;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_clk_en <= 1'b0;
    wr_en <= 1'b0;
    wr_data <= ~d;
    n_push++;
  endtask : push

  task automatic pop(input int gap);
    repeat (gap) @(posedge clk);
    @(posedge clk);
    rd_clk_en <= 1'b1;
    rd_strobe <= 1'b1;
    @(posedge clk);
    rd_clk_en <= 1'b0;
    rd_strobe <= 1'b0;
    n_pop++;
  endtask : pop
endmodule : bfc_user_model

`default_nettype wire

/* sim/test_block_ram_fifo_core.sv */
// test_block_ram_fifo_core: directed bench for bfc_top over ahb-lite, ram ports and fifo sides
// assumes: bfc_top, bfc_user_model and bfc_top_assertions are compiled first
`default_nettype none
`include "bfc_consts.svh"

module test_block_ram_fifo_core;
  timeunit 1ns;
  timeprecision 1ps;
  logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, irq;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata, rv;
  logic        a_en, a_we, b_en, b_we, wr_clk_en, wr_en, rd_clk_en, rd_strobe;
  logic        fifo_reset, rd_ptr_clear, port_a_latch_clear, port_b_latch_clear, chip_wide_clear_n;
  logic        full_flag, almost_full_flag, almost_empty_flag, empty_flag;
  logic [8:0]  a_addr, b_addr;
  logic [17:0] a_din, b_din, a_dout, b_dout, wr_data;
  logic [31:0] ex [3] = '{32'h01234, 32'h35555, 32'h0aaaa};
  logic [31:0] rst_tab [8] = '{32'h0, 32'h1ff, 32'h1c0, 32'h40, 32'h3, 32'h0, 32'h0, 32'h0};
  int          errors, num_checks, cyc;

  assign hready = hreadyout;
  always #2.5 hclk = ~hclk;

  bfc_top dut_u (.*);
  bfc_user_model user_u (.clk(hclk), .wr_data(wr_data), .wr_clk_en(wr_clk_en), .wr_en(wr_en),
    .rd_clk_en(rd_clk_en), .rd_strobe(rd_strobe));

  task automatic final_report;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : final_report

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // master waits on hready with no assumed latency; only the cycle ceiling ends a hang
  task automatic ahb(input logic we, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge hclk);
    htrans <= 2'b10;
    hwrite <= we;
    haddr <= {24'h000000, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : ahb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    ahb(1'b1, a, d, rv);
  endtask : wr

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    ahb(1'b0, a, 32'h0, rv);
    chk(rv, e);
  endtask : rchk

  task automatic pa(input logic p, input logic we, input logic [8:0] ad, input logic [17:0] d);
    @(posedge hclk);
    if (p) begin
      {b_en, b_we, b_addr, b_din} <= {1'b1, we, ad, d};
    end else begin
      {a_en, a_we, a_addr, a_din} <= {1'b1, we, ad, d};
    end
    @(posedge hclk);
    a_en <= 1'b0;
    b_en <= 1'b0;
    @(negedge hclk);
  endtask : pa

  task automatic fl(input logic [3:0] e);
    @(negedge hclk);
    chk({28'h0, full_flag, almost_full_flag, almost_empty_flag, empty_flag}, {28'h0, e});
  endtask : fl

  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      errors++;
      final_report;
    end
  end

  initial begin
    {hclk, hresetn, hsel, hwrite, htrans, haddr, hwdata, cyc, errors, num_checks} = '0;
    hsize = 3'b010;
    {a_en, a_we, a_addr, a_din, b_en, b_we, b_addr, b_din} = '0;
    {fifo_reset, rd_ptr_clear, port_a_latch_clear, port_b_latch_clear} = '0;
    chip_wide_clear_n = 1'b1;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    hsel <= 1'b1;
    fl(4'b0011);
    for (int i = 0; i < 8; i++) rchk(8'(4 * i), rst_tab[i]);
    wr(8'h1c, 32'hffffffff);
    rchk(8'h1c, 32'h0);
    // each mode on each port: normal keeps, through copies, rbw shows the old word
    for (int m = 0; m < 3; m++) begin
      wr(8'h00, {28'h0, m[1:0], m[1:0]});
      for (int p = 0; p < 2; p++) begin
        pa(p[0], 1'b1, 9'h010, 18'h0aaaa);
        pa(p[0], 1'b1, 9'h020, 18'h01234);
        pa(p[0], 1'b0, 9'h020, 18'h0);
        pa(p[0], 1'b1, 9'h010, 18'h35555);
        chk({14'h0, p ? b_dout : a_dout}, ex[m]);
        pa(p[0], 1'b0, 9'h010, 18'h0);
        chk({14'h0, p ? b_dout : a_dout}, 32'h35555);
      end
    end
    for (int am = 0; am < 2; am++) begin
      wr(8'h00, {27'h0, am[0], 4'h0});
      for (int p = 0; p < 2; p++) begin
        pa(1'b0, 1'b0, 9'h020, 18'h0);
        pa(1'b1, 1'b0, 9'h010, 18'h0);
        @(posedge hclk);
        if (p) port_b_latch_clear <= 1'b1;
        else port_a_latch_clear <= 1'b1;
        @(negedge hclk);
        chk({14'h0, p ? b_dout : a_dout}, am ? 32'h0 : ex[p]);
        @(posedge hclk);
        port_a_latch_clear <= 1'b0;
        port_b_latch_clear <= 1'b0;
        @(negedge hclk);
        chk({14'h0, p ? b_dout : a_dout}, 32'h0);
        chk({14'h0, p ? a_dout : b_dout}, ex[1 - p]);
      end
    end
    pa(1'b0, 1'b0, 9'h020, 18'h0);
    pa(1'b1, 1'b0, 9'h010, 18'h0);
    @(posedge hclk);
    chip_wide_clear_n <= 1'b0;
    @(posedge hclk);
    chip_wide_clear_n <= 1'b1;
    @(negedge hclk);
    chk({14'h0, a_dout | b_dout}, 32'h0);
    // fifo: full at 4 words, fifth push refused, refusal interrupts unmasked
    wr(8'h00, 32'h20);
    wr(8'h04, 32'h4);
    wr(8'h08, 32'h3);
    wr(8'h0c, 32'h1);
    wr(8'h18, 32'h30);
    for (int i = 0; i < 5; i++) user_u.push(18'h00100 + 18'(i), i % 2);
    fl(4'b1100);
    rchk(8'h10, 32'h4c);
    rchk(8'h14, 32'h13);
    chk({31'h0, irq}, 32'h1);
    wr(8'h14, 32'h13);
    rchk(8'h14, 32'h0);
    chk({31'h0, irq}, 32'h0);
    for (int i = 0; i < 4; i++) begin
      user_u.pop(i % 2);
      @(negedge hclk);
      chk({14'h0, b_dout}, 32'h100 + i);
    end
    fl(4'b0011);
    user_u.pop(0);
    fl(4'b0011);
    chk({14'h0, b_dout}, 32'h103);
    rchk(8'h14, 32'h2c);
    @(posedge hclk);
    rd_ptr_clear <= 1'b1;
    @(posedge hclk);
    rd_ptr_clear <= 1'b0;
    fl(4'b1100);
    user_u.pop(0);
    @(negedge hclk);
    chk({14'h0, b_dout}, 32'h100);
    @(posedge hclk);
    fifo_reset <= 1'b1;
    @(posedge hclk);
    fifo_reset <= 1'b0;
    fl(4'b0011);
    rchk(8'h10, 32'h3);
    user_u.push(18'h002aa, 0);
    user_u.pop(0);
    @(negedge hclk);
    chk({14'h0, b_dout}, 32'h2aa);
    wr(8'h04, 32'h0);
    rchk(8'h04, 32'h1);
    wr(8'h04, 32'h1ff);
    wr(8'h08, 32'h1ff);
    rchk(8'h08, 32'h1fe);
    wr(8'h0c, 32'h0);
    rchk(8'h0c, 32'h1);
    final_report;
  end
endmodule : test_block_ram_fifo_core

bind bfc_top bfc_top_assertions chk_u (.*);

`default_nettype wire
